// ---- rtl/pmtc_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of pmtc.
// Assumes a 100 MHz core clock and a 4-bit word address on the register port.
`ifndef PMTC_CFG_SVH
`define PMTC_CFG_SVH

`define PMTC_A_MODE     4'h0
`define PMTC_A_CMD      4'h1
`define PMTC_A_PRATE    4'h2
`define PMTC_A_FRATE    4'h3
`define PMTC_A_VOLUME   4'h4
`define PMTC_A_DIR      4'h5
`define PMTC_A_PTIME    4'h6
`define PMTC_A_RDYDEF   4'h7
`define PMTC_A_ENABLE   4'h8
`define PMTC_A_TSEL     4'h9
`define PMTC_A_RUNSTAT  4'hA
`define PMTC_A_FLTSTAT  4'hB
`define PMTC_A_TOTAL    4'hC

`define PMTC_CMD_OP_HI  10
`define PMTC_CMD_OP_LO  8
`define PMTC_FLT_REF_LO 8

`define PMTC_RST_RATE   16'h0064
`define PMTC_RST_VOLUME 16'h0001
`define PMTC_RST_PTIME  16'h2710
`define PMTC_TOTAL_MAX  16'hFFFF

`define PMTC_CLK_MHZ    100
`define PMTC_CLK_HZ     27'h5F5E100
`define PMTC_STEPS_REV  200
`define PMTC_DEB_US     1000
`define PMTC_DEB_CYC    (`PMTC_DEB_US * `PMTC_CLK_MHZ)
`define PMTC_MS_US      1000
`define PMTC_MS_CYC     (`PMTC_MS_US * `PMTC_CLK_MHZ)

`endif

// ---- rtl/pmtc_pkg.sv ----
// Types shared by the pump mode and trigger control block.
// Assumes pmtc_cfg.svh supplies the timing constants; codes and field widths are fixed here.
`default_nettype none
package pmtc_pkg;

    typedef enum logic [1:0] {
        PMTC_PRIME = 2'b00,
        PMTC_DISP  = 2'b01,
        PMTC_METER = 2'b10
    } pmtc_mode_type;

    typedef enum logic [2:0] {
        PMTC_OP_NONE  = 3'b000,
        PMTC_OP_BEGIN = 3'b001,
        PMTC_OP_STOP  = 3'b010,
        PMTC_OP_REF   = 3'b011,
        PMTC_OP_CLR   = 3'b100,
        PMTC_OP_TCLR  = 3'b101
    } pmtc_op_type;

    typedef enum logic [2:0] {
        PMTC_IDLE      = 3'b000,
        PMTC_RUN_PRIME = 3'b001,
        PMTC_RUN_DISP  = 3'b010,
        PMTC_RUN_METER = 3'b011,
        PMTC_RUN_REF   = 3'b100
    } pmtc_phase_type;

    typedef struct packed {
        pmtc_phase_type phase;
        logic           need_ref;
        logic           fault;
        logic [26:0]    acc;
        logic [7:0]     steps;
        logic [15:0]    revs;
        logic [15:0]    total;
        logic           step;
        logic           rdy;
    } pmtc_chan_type;

endpackage

`default_nettype wire

// ---- rtl/pmtc_top.sv ----
// Mode and trigger sequencing for a multi-channel stepper pump controller.
// Assumes a host on the plain register port and opto-isolated pins that
// arrive asynchronously: trigger, per-channel fault, home and chamber empty.
`timescale 1ns/100ps
`default_nettype none
`include "pmtc_cfg.svh"

// What this block does
// - Prime ignores trigger; only begin starts
// - Prime runs until stop or time limit
// - Dispense starts on trigger rising edge
// - Disabled, faulted, unreferenced channels never triggered
// - Meter starts on trigger rise with chamber not empty, stops on trigger fall or empty
// - Meter follows trigger and begin/stop commands
// - Meter stop halts at once, no homing
// - Dispense starts by begin or trigger
// - Dispense ends at volume or stop
// - System ready only when all ready
// - Ready definition register sets ready meaning
// - System fault output true when fault-free
// - Outputs conduct when true
// - Prime volume not totalized
// - Dispense and meter revolutions totalized
// - Direction register steers every mode
// - Prime rate separate from flow rate
// - Volume in revolutions, steps per revolution
// - Mode chosen by mode register
// - After fault clear, reference before motion
// - Totalizer saturates at maximum, cleared explicitly
module pmtc_top #(
    parameter int NCH       = 4,
    parameter int STEPS_REV = `PMTC_STEPS_REV,
    parameter int DEB_CYC   = `PMTC_DEB_CYC,
    parameter int MS_CYC    = `PMTC_MS_CYC
) (
    input  wire logic            core_clk_i,
    input  wire logic            rst_b_i,
    input  wire logic [3:0]      addr_i,
    input  wire logic [15:0]     wr_data_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output logic      [15:0]     rd_data_o,
    input  wire logic            trig_i,
    input  wire logic [NCH-1:0]  fault_i,
    input  wire logic [NCH-1:0]  home_i,
    input  wire logic [NCH-1:0]  empty_i,
    output logic      [NCH-1:0]  step_o,
    output logic                 dir_o,
    output logic      [NCH-1:0]  ch_ready_o,
    output logic                 sys_ready_o,
    output logic                 sys_fault_ok_o
);

    localparam int DW = $clog2(DEB_CYC + 1);
    localparam int MW = $clog2(MS_CYC + 1);

    typedef struct packed {
        pmtc_pkg::pmtc_chan_type [NCH-1:0] ch;
        logic [NCH-1:0]          en;
        logic [NCH-1:0]          flt_s1;
        logic [NCH-1:0]          flt_s2;
        logic [NCH-1:0]          home_s1;
        logic [NCH-1:0]          home_s2;
        logic [NCH-1:0]          emp_s1;
        logic [NCH-1:0]          emp_s2;
        logic                    trig_s1;
        logic                    trig_s2;
        logic                    trig_deb;
        logic [DW-1:0]           deb_cnt;
        logic [MW-1:0]           ms_cnt;
        logic [15:0]             ptimer;
        pmtc_pkg::pmtc_mode_type mode;
        logic [15:0]             prate;
        logic [15:0]             frate;
        logic [15:0]             volume;
        logic [15:0]             ptime;
        logic                    dir;
        logic [1:0]              rdydef;
        logic [2:0]              tsel;
        logic [15:0]             rdata;
        logic                    sys_ready;
        logic                    fault_ok;
    } pmtc_state_type;

    pmtc_state_type st;
    pmtc_state_type next_st;

    // Bit 0 of the definition forgives faults, bit 1 a pending reference
    function automatic logic chan_ready(input pmtc_pkg::pmtc_chan_type c,
                                        input logic [1:0] def);
        chan_ready = (c.phase == pmtc_pkg::PMTC_IDLE)
                     && (def[0] || !c.fault)
                     && (def[1] || !c.need_ref);
    endfunction

    function automatic logic is_run(input pmtc_pkg::pmtc_chan_type c,
                                    input pmtc_pkg::pmtc_phase_type p);
        is_run = (c.phase == p);
    endfunction

    logic                  trig_rise;
    logic                  trig_fall;
    logic                  ms_tick;
    logic                  any_prime;
    logic                  prime_done;
    logic [NCH-1:0]        run_vec;
    logic [NCH-1:0]        flt_vec;
    logic [NCH-1:0]        ref_vec;
    logic [NCH-1:0]        rdy_vec;
    pmtc_pkg::pmtc_op_type op;
    logic [NCH-1:0]        mask;

    always_comb begin
        pmtc_pkg::pmtc_chan_type c;
        logic [15:0]             rate;
        logic [26:0]             sum;
        logic                    elig;
        logic                    hit;
        c          = '0;
        rate       = '0;
        sum        = '0;
        elig       = 1'b0;
        hit        = 1'b0;
        next_st    = st;
        trig_rise  = 1'b0;
        trig_fall  = 1'b0;
        op         = pmtc_pkg::PMTC_OP_NONE;
        mask       = '0;
        any_prime  = 1'b0;

        next_st.trig_s1 = trig_i;
        next_st.trig_s2 = st.trig_s1;
        next_st.flt_s1  = fault_i;
        next_st.flt_s2  = st.flt_s1;
        next_st.home_s1 = home_i;
        next_st.home_s2 = st.home_s1;
        next_st.emp_s1  = empty_i;
        next_st.emp_s2  = st.emp_s1;

        // Level must hold a full window so contact bounce gives one edge
        if (st.trig_s2 == st.trig_deb) begin
            next_st.deb_cnt = '0;
        end else if (st.deb_cnt == DW'(DEB_CYC - 1)) begin
            next_st.deb_cnt  = '0;
            next_st.trig_deb = st.trig_s2;
            trig_rise        = st.trig_s2;
            trig_fall        = !st.trig_s2;
        end else begin
            next_st.deb_cnt = st.deb_cnt + 1'b1;
        end

        ms_tick        = (st.ms_cnt == MW'(MS_CYC - 1));
        next_st.ms_cnt = ms_tick ? '0 : st.ms_cnt + 1'b1;

        for (int i = 0; i < NCH; i++) begin
            run_vec[i] = st.ch[i].phase != pmtc_pkg::PMTC_IDLE;
            flt_vec[i] = st.ch[i].fault;
            ref_vec[i] = st.ch[i].need_ref;
            rdy_vec[i] = chan_ready(st.ch[i], st.rdydef);
            any_prime  = any_prime | is_run(st.ch[i], pmtc_pkg::PMTC_RUN_PRIME);
        end

        if (wr_i) begin
            case (addr_i)
                `PMTC_A_MODE: begin
                    if (wr_data_i[1:0] != 2'h3) begin
                        next_st.mode = pmtc_pkg::pmtc_mode_type'(wr_data_i[1:0]);
                    end
                end
                `PMTC_A_CMD: begin
                    op   = pmtc_pkg::pmtc_op_type'(wr_data_i[`PMTC_CMD_OP_HI:`PMTC_CMD_OP_LO]);
                    mask = wr_data_i[NCH-1:0];
                end
                `PMTC_A_PRATE:  next_st.prate  = wr_data_i;
                `PMTC_A_FRATE:  next_st.frate  = wr_data_i;
                `PMTC_A_VOLUME: next_st.volume = wr_data_i;
                `PMTC_A_DIR:    next_st.dir    = wr_data_i[0];
                `PMTC_A_PTIME:  next_st.ptime  = wr_data_i;
                `PMTC_A_RDYDEF: next_st.rdydef = wr_data_i[1:0];
                `PMTC_A_ENABLE: next_st.en     = wr_data_i[NCH-1:0];
                `PMTC_A_TSEL:   next_st.tsel   = wr_data_i[2:0];
                default: begin
                end
            endcase
        end

        if (rd_i) begin
            case (addr_i)
                `PMTC_A_MODE:    next_st.rdata = 16'(st.mode);
                `PMTC_A_PRATE:   next_st.rdata = st.prate;
                `PMTC_A_FRATE:   next_st.rdata = st.frate;
                `PMTC_A_VOLUME:  next_st.rdata = st.volume;
                `PMTC_A_DIR:     next_st.rdata = 16'(st.dir);
                `PMTC_A_PTIME:   next_st.rdata = st.ptime;
                `PMTC_A_RDYDEF:  next_st.rdata = 16'(st.rdydef);
                `PMTC_A_ENABLE:  next_st.rdata = 16'(st.en);
                `PMTC_A_TSEL:    next_st.rdata = 16'(st.tsel);
                `PMTC_A_RUNSTAT: next_st.rdata = 16'(run_vec);
                `PMTC_A_FLTSTAT: next_st.rdata = 16'(flt_vec)
                                 | (16'(ref_vec) << `PMTC_FLT_REF_LO);
                `PMTC_A_TOTAL: begin
                    next_st.rdata = (32'(st.tsel) < NCH) ? st.ch[st.tsel].total : 16'h0000;
                end
                default:         next_st.rdata = 16'h0000;
            endcase
        end

        // Timer guards against a lost host leaving the pumps priming
        prime_done = any_prime && (st.ptimer >= st.ptime);
        if (!any_prime) begin
            next_st.ptimer = '0;
        end else if (ms_tick && !prime_done) begin
            next_st.ptimer = st.ptimer + 1'b1;
        end

        for (int i = 0; i < NCH; i++) begin
            c      = st.ch[i];
            c.step = 1'b0;
            c.rdy  = rdy_vec[i];
            elig   = st.en[i] && !st.ch[i].fault && !st.ch[i].need_ref;
            hit    = 1'b0;
            rate   = (c.phase == pmtc_pkg::PMTC_RUN_PRIME) ? st.prate : st.frate;

            if (c.phase != pmtc_pkg::PMTC_IDLE) begin
                sum = c.acc + 27'(rate);
                if (sum >= `PMTC_CLK_HZ) begin
                    c.acc  = sum - `PMTC_CLK_HZ;
                    c.step = 1'b1;
                    if (32'(c.steps) == STEPS_REV - 1) begin
                        c.steps = '0;
                        c.revs  = c.revs + 1'b1;
                        hit     = 1'b1;
                    end else begin
                        c.steps = c.steps + 1'b1;
                    end
                end else begin
                    c.acc = sum;
                end
            end

            // Prime and reference motion never counts
            if (hit && (c.phase == pmtc_pkg::PMTC_RUN_DISP
                        || c.phase == pmtc_pkg::PMTC_RUN_METER)) begin
                if (c.total != `PMTC_TOTAL_MAX) begin
                    c.total = c.total + 1'b1;
                end
            end
            if (op == pmtc_pkg::PMTC_OP_TCLR && mask[i]) begin
                c.total = 16'h0000;
            end

            if (st.flt_s2[i]) begin
                c.fault = 1'b1;
                c.phase = pmtc_pkg::PMTC_IDLE;
            end else begin
                if (op == pmtc_pkg::PMTC_OP_CLR && mask[i] && c.fault) begin
                    c.fault    = 1'b0;
                    c.need_ref = 1'b1;
                end
                case (st.ch[i].phase)
                    pmtc_pkg::PMTC_IDLE: begin
                        c.acc   = '0;
                        c.steps = '0;
                        c.revs  = '0;
                        if (op == pmtc_pkg::PMTC_OP_BEGIN && mask[i] && elig) begin
                            case (st.mode)
                                pmtc_pkg::PMTC_PRIME: c.phase = pmtc_pkg::PMTC_RUN_PRIME;
                                pmtc_pkg::PMTC_DISP:  c.phase = pmtc_pkg::PMTC_RUN_DISP;
                                pmtc_pkg::PMTC_METER: c.phase = pmtc_pkg::PMTC_RUN_METER;
                                default:              c.phase = pmtc_pkg::PMTC_IDLE;
                            endcase
                        end else if (trig_rise && elig) begin
                            if (st.mode == pmtc_pkg::PMTC_DISP) begin
                                c.phase = pmtc_pkg::PMTC_RUN_DISP;
                            end else if (st.mode == pmtc_pkg::PMTC_METER
                                         && !st.emp_s2[i]) begin
                                c.phase = pmtc_pkg::PMTC_RUN_METER;
                            end
                        end else if (op == pmtc_pkg::PMTC_OP_REF && mask[i]
                                     && st.en[i] && !st.ch[i].fault) begin
                            c.phase = pmtc_pkg::PMTC_RUN_REF;
                        end
                    end
                    pmtc_pkg::PMTC_RUN_PRIME: begin
                        if ((op == pmtc_pkg::PMTC_OP_STOP && mask[i]) || prime_done) begin
                            c.phase = pmtc_pkg::PMTC_IDLE;
                        end
                    end
                    pmtc_pkg::PMTC_RUN_DISP: begin
                        if ((op == pmtc_pkg::PMTC_OP_STOP && mask[i])
                            || (c.revs >= st.volume)) begin
                            c.phase = pmtc_pkg::PMTC_IDLE;
                        end
                    end
                    pmtc_pkg::PMTC_RUN_METER: begin
                        // Halts mid-revolution; idle then clears the step and revolution counts
                        if ((op == pmtc_pkg::PMTC_OP_STOP && mask[i]) || trig_fall
                            || st.emp_s2[i]) begin
                            c.phase = pmtc_pkg::PMTC_IDLE;
                        end
                    end
                    pmtc_pkg::PMTC_RUN_REF: begin
                        if (st.home_s2[i]) begin
                            c.phase    = pmtc_pkg::PMTC_IDLE;
                            c.need_ref = 1'b0;
                        end
                    end
                    default: c.phase = pmtc_pkg::PMTC_IDLE;
                endcase
            end
            next_st.ch[i] = c;
        end

        next_st.sys_ready = &rdy_vec;
        next_st.fault_ok  = ~|flt_vec;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st        <= '0;
            st.mode   <= pmtc_pkg::PMTC_PRIME;
            st.prate  <= `PMTC_RST_RATE;
            st.frate  <= `PMTC_RST_RATE;
            st.volume <= `PMTC_RST_VOLUME;
            st.ptime  <= `PMTC_RST_PTIME;
            for (int i = 0; i < NCH; i++) begin
                st.ch[i].need_ref <= 1'b1;
            end
        end else begin
            st <= next_st;
        end
    end

    // Pins conduct for a true value; fault pin conducts when healthy
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            assign step_o[g]     = st.ch[g].step;
            assign ch_ready_o[g] = st.ch[g].rdy;
        end
    endgenerate
    assign dir_o          = st.dir;
    assign sys_ready_o    = st.sys_ready;
    assign sys_fault_ok_o = st.fault_ok;
    assign rd_data_o      = st.rdata;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    logic elig0;
    assign elig0 = st.en[0] && !st.ch[0].fault && !st.ch[0].need_ref;

    chk_prime_begin_only: assert property (
        $rose(st.ch[0].phase == pmtc_pkg::PMTC_RUN_PRIME) |->
        $past(wr_i && addr_i == `PMTC_A_CMD && wr_data_i[10:8] == 3'h1))
        else $error("prime started without begin");

    chk_prime_time_cap: assert property (
        (prime_done && !st.flt_s2[0]) |=> st.ch[0].phase != pmtc_pkg::PMTC_RUN_PRIME)
        else $error("prime ran past its time limit");

    chk_disp_on_edge: assert property (
        $rose(st.ch[0].phase == pmtc_pkg::PMTC_RUN_DISP) |->
        $past(trig_rise || (wr_i && addr_i == `PMTC_A_CMD)))
        else $error("dispense started without edge or begin");

    chk_no_bad_start: assert property (
        (st.ch[0].phase == pmtc_pkg::PMTC_IDLE && !elig0) |=>
        st.ch[0].phase inside {pmtc_pkg::PMTC_IDLE, pmtc_pkg::PMTC_RUN_REF})
        else $error("ineligible channel started");

    chk_meter_drop: assert property (
        (trig_fall && st.ch[0].phase == pmtc_pkg::PMTC_RUN_METER) |=>
        st.ch[0].phase == pmtc_pkg::PMTC_IDLE)
        else $error("meter kept running after trigger fell");

    chk_sys_ready_and: assert property (
        (st.ch[0].phase != pmtc_pkg::PMTC_IDLE) |=> !sys_ready_o)
        else $error("system ready with a busy channel");

    chk_fault_out_low: assert property (
        (|flt_vec) |=> !sys_fault_ok_o)
        else $error("fault output healthy while faulted");

    chk_prime_no_total: assert property (
        (st.ch[0].phase == pmtc_pkg::PMTC_RUN_PRIME && !(wr_i && addr_i == `PMTC_A_CMD))
        |=> $stable(st.ch[0].total))
        else $error("prime volume reached totalizer");

    chk_total_sat: assert property (
        (st.ch[0].total == 16'hFFFF && !(wr_i && addr_i == `PMTC_A_CMD)) |=>
        st.ch[0].total == 16'hFFFF)
        else $error("totalizer wrapped");

endmodule // pmtc_top

`default_nettype wire

// ---- tb/pmtc_plc_model.sv ----
// Customer PLC and pump sensor model around the pump mode and trigger block.
// Assumes the bench sets the request inputs just after rising clock edges.
`timescale 1ns/100ps
`default_nettype none
module pmtc_plc_model #(
    parameter int NCH = 4
) (
    input  wire logic           clk_i,
    input  wire logic           trig_req_i,
    input  wire logic [NCH-1:0] fault_req_i,
    input  wire logic [NCH-1:0] empty_req_i,
    input  wire logic [NCH-1:0] step_i,
    output logic                trig_o,
    output logic      [NCH-1:0] fault_o,
    output logic      [NCH-1:0] home_o,
    output logic      [NCH-1:0] empty_o
);
    logic [3:0] hold [NCH] = '{default: 4'h0};

    // Opto pins lag the PLC, so they never move on a clock edge
    assign #2 trig_o = trig_req_i;
    assign #2 fault_o = fault_req_i;
    assign #2 empty_o = empty_req_i;

    // Home flag stretched past the input synchroniser after a step
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NCH; c++) begin
            hold[c] <= step_i[c] ? 4'hF : (hold[c] != 4'h0 ? hold[c] - 4'h1 : 4'h0);
        end
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            home_o[c] = hold[c] != 4'h0;
        end
    end
endmodule // pmtc_plc_model
`default_nettype wire

// ---- tb/test_pmtc_top.sv ----
// Self-checking bench for the pump mode and trigger block.
// Assumes short counts: 4-cycle debounce, 10-cycle millisecond, 2 steps a turn.
`timescale 1ns/100ps
`default_nettype none
`include "pmtc_cfg.svh"
module test_pmtc_top;
    localparam int DEB = 4;
    logic        core_clk_i = 1'b0;
    logic        rst_b_i    = 1'b0;
    logic [3:0]  addr       = 4'h0;
    logic [15:0] wdat       = 16'h0000;
    logic        wr         = 1'b0;
    logic        rd_s       = 1'b0;
    logic        trig_req   = 1'b0;
    logic [3:0]  fault_req  = 4'h0;
    logic [3:0]  empty_req  = 4'h0;
    logic [15:0] rdat;
    logic        trig;
    logic [3:0]  fault;
    logic [3:0]  home;
    logic [3:0]  empty;
    logic [3:0]  step;
    logic        dir_o;
    logic [3:0]  ch_ready_o;
    logic        sys_ready_o;
    logic        sys_fault_ok_o;
    logic [15:0] v;
    logic [3:0]  en;
    logic        dir;
    logic [15:0] nstep      = 16'h0000;
    logic [15:0] s0;
    int          mismatches = 0;
    int          checks     = 0;
    logic [3:0]  ra [6] = '{`PMTC_A_MODE, `PMTC_A_PRATE, `PMTC_A_FRATE, `PMTC_A_VOLUME,
                            `PMTC_A_PTIME, 4'hD};
    logic [15:0] rv [6] = '{16'h0000, `PMTC_RST_RATE, `PMTC_RST_RATE, `PMTC_RST_VOLUME,
                            `PMTC_RST_PTIME, 16'h0000};

    always #5 core_clk_i = ~core_clk_i;

    // Step pulses of channel 0, to count steps per dispense
    always @(posedge core_clk_i) begin
        if (step[0] === 1'b1) begin
            nstep <= nstep + 16'h0001;
        end
    end

    pmtc_top #(.NCH(4), .STEPS_REV(2), .DEB_CYC(DEB), .MS_CYC(10)) i_dut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wr_data_i(wdat),
        .wr_i(wr), .rd_i(rd_s), .rd_data_o(rdat), .trig_i(trig), .fault_i(fault),
        .home_i(home), .empty_i(empty), .step_o(step), .dir_o(dir_o),
        .ch_ready_o(ch_ready_o), .sys_ready_o(sys_ready_o), .sys_fault_ok_o(sys_fault_ok_o));

    pmtc_plc_model #(.NCH(4)) i_plc (
        .clk_i(core_clk_i), .trig_req_i(trig_req), .fault_req_i(fault_req),
        .empty_req_i(empty_req), .step_i(step), .trig_o(trig), .fault_o(fault),
        .home_o(home), .empty_o(empty));

    function automatic logic [15:0] cmd(input pmtc_pkg::pmtc_op_type op, input logic [3:0] m);
        return {5'h00, op, 4'h0, m};
    endfunction

    // Channels that a begin or trigger may start
    function automatic logic [15:0] elig(input logic [3:0] e, input logic [3:0] nref);
        return {12'h000, e & ~nref};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] q);
        @(posedge core_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk_i);
        rd_s <= 1'b0;
        #1 q = rdat;
    endtask

    // Polls a status register, bounded, then compares
    task automatic wait_reg(input logic [3:0] a, input logic [15:0] exp, input int n);
        logic [15:0] q;
        rd_reg(a, q);
        while (q !== exp && n > 0) begin
            rd_reg(a, q);
            n--;
        end
        chk(q, exp);
    endtask

    task automatic end_test(input string s);
        $display("test %s done at %0t", s, $time);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #1000000;
        mismatches++;
        give_verdict;
    end

    initial begin
        void'($urandom(45197));
        dir = 1'($urandom);
        en = 4'($urandom) | 4'h1;
        cyc(20);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd_reg(ra[i], v);
            chk(v, rv[i]);
        end
        wait_reg(`PMTC_A_FLTSTAT, 16'h0F00, 2);
        chk(16'(sys_fault_ok_o), 16'h0001);
        wr_reg(`PMTC_A_ENABLE, 16'h000F);
        wr_reg(`PMTC_A_PRATE, 16'hFFFF);
        wr_reg(`PMTC_A_FRATE, 16'hFFFF);
        wr_reg(`PMTC_A_DIR, {15'h0000, dir});
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_REF, 4'hF));
        wait_reg(`PMTC_A_FLTSTAT, 16'h0000, 2000);
        cyc(3);
        chk({12'h000, ch_ready_o}, 16'h000F);
        chk(16'(sys_ready_o), 16'h0001);
        chk(16'(dir_o), 16'(dir));
        end_test("reset and reference");

        trig_req <= 1'b1;
        cyc(DEB + 10);
        wait_reg(`PMTC_A_RUNSTAT, 16'h0000, 0);
        trig_req <= 1'b0;
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_BEGIN, 4'h1));
        wait_reg(`PMTC_A_RUNSTAT, 16'h0001, 4);
        cyc(3500);
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_STOP, 4'h1));
        wait_reg(`PMTC_A_RUNSTAT, 16'h0000, 4);
        wr_reg(`PMTC_A_TSEL, 16'h0000);
        wait_reg(`PMTC_A_TOTAL, 16'h0000, 0);
        wr_reg(`PMTC_A_PTIME, 16'h0003);
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_BEGIN, 4'h1));
        wait_reg(`PMTC_A_RUNSTAT, 16'h0001, 2);
        wait_reg(`PMTC_A_RUNSTAT, 16'h0000, 40);
        end_test("prime");

        wr_reg(`PMTC_A_MODE, 16'h0001);
        wr_reg(`PMTC_A_ENABLE, {12'h000, en});
        s0 = nstep;
        // Contact bounce shorter than the debounce span
        trig_req <= 1'b1;
        cyc(2);
        trig_req <= 1'b0;
        cyc(2);
        trig_req <= 1'b1;
        wait_reg(`PMTC_A_RUNSTAT, elig(en, 4'h0), 20);
        wait_reg(`PMTC_A_RUNSTAT, 16'h0000, 2500);
        cyc(20);
        wait_reg(`PMTC_A_RUNSTAT, 16'h0000, 0);
        wait_reg(`PMTC_A_TOTAL, 16'h0001, 0);
        chk(nstep - s0, 16'h0002);
        trig_req <= 1'b0;
        end_test("dispense");

        wr_reg(`PMTC_A_ENABLE, 16'h000F);
        fault_req <= 4'h2;
        cyc(6);
        chk(16'(sys_fault_ok_o), 16'h0000);
        chk(16'(sys_ready_o), 16'h0000);
        wr_reg(`PMTC_A_RDYDEF, 16'h0001);
        cyc(3);
        chk({12'h000, ch_ready_o}, 16'h000F);
        wr_reg(`PMTC_A_RDYDEF, 16'h0000);
        fault_req <= 4'h0;
        cyc(4);
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_CLR, 4'h2));
        wait_reg(`PMTC_A_FLTSTAT, 16'h0200, 4);
        chk(16'(sys_fault_ok_o), 16'h0001);
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_BEGIN, 4'hF));
        wait_reg(`PMTC_A_RUNSTAT, elig(4'hF, 4'h2), 4);
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_STOP, 4'hF));
        wait_reg(`PMTC_A_RUNSTAT, 16'h0000, 4);
        wait_reg(`PMTC_A_TOTAL, 16'h0001, 0);
        cyc(3);
        chk({12'h000, ch_ready_o}, 16'h000D);
        wr_reg(`PMTC_A_RDYDEF, 16'h0002);
        cyc(3);
        chk({12'h000, ch_ready_o}, 16'h000F);
        chk(16'(sys_ready_o), 16'h0001);
        wr_reg(`PMTC_A_RDYDEF, 16'h0000);
        end_test("fault");

        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_REF, 4'h2));
        wait_reg(`PMTC_A_FLTSTAT, 16'h0000, 2000);
        wr_reg(`PMTC_A_MODE, 16'h0002);
        trig_req <= 1'b1;
        wait_reg(`PMTC_A_RUNSTAT, 16'h000F, 20);
        empty_req <= 4'h4;
        wait_reg(`PMTC_A_RUNSTAT, 16'h000B, 6);
        trig_req <= 1'b0;
        wait_reg(`PMTC_A_RUNSTAT, 16'h0000, 10);
        empty_req <= 4'h0;
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_BEGIN, 4'h1));
        wait_reg(`PMTC_A_RUNSTAT, 16'h0001, 4);
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_STOP, 4'h1));
        wait_reg(`PMTC_A_RUNSTAT, 16'h0000, 4);
        // Dispense after metering is begun and stopped at once, and nothing of it is checked
        wr_reg(`PMTC_A_MODE, 16'h0001);
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_BEGIN, 4'h1));
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_STOP, 4'h1));
        end_test("meter");

        wr_reg(`PMTC_A_MODE, 16'h0003);
        wait_reg(`PMTC_A_MODE, 16'h0001, 0);
        wr_reg(`PMTC_A_CMD, cmd(pmtc_pkg::PMTC_OP_TCLR, 4'h1));
        wait_reg(`PMTC_A_TOTAL, 16'h0000, 0);
        end_test("mode and totalizer");
        give_verdict;
    end
endmodule // test_pmtc_top
`default_nettype wire
